// [bridge_cfg_pkg.sv]
/*
  Constants for the bridge configuration header bank: byte offsets,
  reset values, writable-bit masks and the I/O window decode layout.
  Assumes byte-wide configuration access at the byte offsets below.
*/
package bridge_cfg_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int CFG_ADDR_W = 8;
  localparam int CFG_DATA_W = 8;
  localparam int IO_ADDR_W  = 16;
  localparam int IO_DATA_W  = 32;
  localparam int IO_BE_W    = 4;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_BRIDGE_COMMAND      = 8'h04;
  localparam logic [7:0] OFF_BRIDGE_SUBCLASS     = 8'h0a;
  localparam logic [7:0] OFF_BRIDGE_BASE_CLASS   = 8'h0b;
  localparam logic [7:0] OFF_LATENCY_SCRATCHPAD  = 8'h0d;
  localparam logic [7:0] OFF_HEADER_LAYOUT_TYPE  = 8'h0e;
  localparam logic [7:0] OFF_UPSTREAM_BUS_NUMBER = 8'h18;
  localparam logic [7:0] OFF_DOWNSTREAM_BUS_NUM  = 8'h19;
  localparam logic [7:0] OFF_DOWNSTREAM_LATENCY  = 8'h1b;
  localparam logic [7:0] OFF_IO_WINDOW_LOW       = 8'h1c;
  localparam logic [7:0] OFF_IO_WINDOW_HIGH      = 8'h1d;

  // ---------------------------------------------------------------
  // Reset / hardwired values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BRIDGE_COMMAND      = 8'h00;
  localparam logic [7:0] VAL_SUB_CLASS_CODE      = 8'h04;
  localparam logic [7:0] VAL_BASE_CLASS_CODE     = 8'h06;
  localparam logic [7:0] RST_LATENCY_SCRATCHPAD  = 8'h00;
  localparam logic [7:0] VAL_HEADER_KIND         = 8'h01;
  localparam logic [7:0] VAL_UPSTREAM_BUS_NUMBER = 8'h00;
  localparam logic [7:0] RST_DOWNSTREAM_BUS_NUM  = 8'h00;
  localparam logic [7:0] VAL_DOWNSTREAM_LATENCY  = 8'h00;
  localparam logic [7:0] RST_IO_WINDOW_LOW       = 8'hf0;
  localparam logic [7:0] RST_IO_WINDOW_HIGH      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED             = 8'h00;

  // ---------------------------------------------------------------
  // Writable-bit masks and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] WMASK_BRIDGE_COMMAND    = 8'h01;
  localparam logic [7:0] WMASK_SCRATCH_BITS      = 8'hf8;
  localparam logic [7:0] WMASK_FULL_BYTE         = 8'hff;
  localparam logic [7:0] WMASK_IO_WINDOW         = 8'hf0;
  localparam int         IO_ACCESS_ENABLE_BIT    = 0;
  localparam int         IO_FIELD_MSB            = 7;
  localparam int         IO_FIELD_LSB            = 4;

  // Window granule: low address bits forced on decode
  localparam logic [11:0] IO_LOW_FILL_BASE  = 12'h000;
  localparam logic [11:0] IO_LOW_FILL_LIMIT = 12'hfff;

endpackage

// [masked_cfg_reg.sv]
/*
  One byte-wide configuration register with a per-bit writable mask.
  Bits outside the mask are constant at their reset value.
  Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module masked_cfg_reg #(
  parameter logic [7:0] RESET_VAL  = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wdata_i,
  output wire logic [7:0] value_o
);

  // ---------------------------------------------------------------
  // Per-bit storage
  // ---------------------------------------------------------------
  for (genvar b = 0; b < 8; b++) begin : g_bit
    if (WRITE_MASK[b]) begin : g_rw
      logic bit_reg;
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          bit_reg <= RESET_VAL[b];
        end else if (wr_en_i) begin
          bit_reg <= wdata_i[b];
        end
      end
      assign value_o[b] = bit_reg;
    end else begin : g_ro
      // Read-only bits take no flop; writes cannot reach them
      assign value_o[b] = RESET_VAL[b];
    end
  end

endmodule

`default_nettype wire

// [io_window_match.sv]
/*
  I/O window comparator: base and limit 4-bit fields widened to full
  16-bit bounds, inclusive compare, gated by the access enable.
  Assumes purely combinational use inside a clocked parent.
*/
`timescale 1ns/1ps
`default_nettype none

module io_window_match
  import bridge_cfg_pkg::*;
(
  input  wire logic [3:0]           low_field_i,
  input  wire logic [3:0]           high_field_i,
  input  wire logic                 enable_i,
  input  wire logic [IO_ADDR_W-1:0] addr_i,
  output logic                      hit_o
);

  logic [IO_ADDR_W-1:0] window_bottom;
  logic [IO_ADDR_W-1:0] window_top;

  assign window_bottom = {low_field_i, IO_LOW_FILL_BASE};   // [R9]
  assign window_top    = {high_field_i, IO_LOW_FILL_LIMIT}; // [R10]

  // Base above limit simply yields an empty window
  assign hit_o = enable_i && (addr_i >= window_bottom) && (addr_i <= window_top); // [R11] [R13]

endmodule

`default_nettype wire

// [bridge_config_header_io_window.sv]
/*
  Configuration header bank of an internal virtual bridge function with
  an I/O window that forwards matching host I/O accesses downstream.
  Assumes byte-wide configuration accesses, one per cycle, and host I/O
  requests as single-cycle pulses synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] Offset 0Ah reads sub-class 04h, read-only.
// [R2] Offset 0Bh reads base class 06h, read-only.
// [R3] Offset 0Dh bits 7:3 are scratch storage, reset 00h; bits 2:0 reserved.
// [R4] Offset 0Eh reads header type 01h, read-only.
// [R5] Offset 18h upstream bus number hardwired 00h; writes ignored.
// [R6] Offset 19h downstream bus number, read/write, reset 00h.
// [R7] Offset 1Bh downstream latency register reads 00h, all reserved.
// [R8] Offset 1Ch window base bits 7:4 give address bits 15:12, reset F0h.
// [R9] Window base low twelve address bits are taken as zero.
// [R10] Offset 1Dh window limit bits 7:4, reset 00h; low bits taken as FFFh.
// [R11] Host I/O inside base..limit inclusive goes to the downstream link.
// [R12] Only upper four bits of window registers writable; low four reserved.
// [R13] Window forwards nothing unless command bit 0 is set; resets to 0.
// [R14] Reserved bits read zero; writes to read-only fields do nothing.
module bridge_config_header_io_window
  import bridge_cfg_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Configuration access port
  input  wire logic [CFG_ADDR_W-1:0] cfg_addr_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic [CFG_DATA_W-1:0] cfg_wdata_i,
  input  wire logic                  cfg_rd_i,
  output logic      [CFG_DATA_W-1:0] cfg_rdata_o,
  output logic                       cfg_rvalid_o,
  // Host I/O request
  input  wire logic                  io_req_i,
  input  wire logic [IO_ADDR_W-1:0]  io_addr_i,
  input  wire logic                  io_write_i,
  input  wire logic [IO_DATA_W-1:0]  io_wdata_i,
  input  wire logic [IO_BE_W-1:0]    io_be_i,
  // Downstream link
  output logic                       link_req_o,
  output logic      [IO_ADDR_W-1:0]  link_addr_o,
  output logic                       link_write_o,
  output logic      [IO_DATA_W-1:0]  link_wdata_o,
  output logic      [IO_BE_W-1:0]    link_be_o,
  // Host request not claimed by the window
  output logic                       io_miss_o,
  // Status toward the rest of the chip
  output logic      [7:0]            downstream_bus_o,
  output logic                       io_access_enable_o
);

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  logic wr_command;
  logic wr_scratch;
  logic wr_bus_number;
  logic wr_window_low;
  logic wr_window_high;

  // Only writable registers get a strobe; every other offset,
  // including the read-only identification bytes, drops the write
  assign wr_command     = cfg_wr_i && (cfg_addr_i == OFF_BRIDGE_COMMAND);
  assign wr_scratch     = cfg_wr_i && (cfg_addr_i == OFF_LATENCY_SCRATCHPAD);
  assign wr_bus_number  = cfg_wr_i && (cfg_addr_i == OFF_DOWNSTREAM_BUS_NUM);
  assign wr_window_low  = cfg_wr_i && (cfg_addr_i == OFF_IO_WINDOW_LOW);
  assign wr_window_high = cfg_wr_i && (cfg_addr_i == OFF_IO_WINDOW_HIGH);

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  logic [7:0] bridge_command;
  logic [7:0] latency_scratchpad;
  logic [7:0] downstream_bus_number;
  logic [7:0] io_window_low;
  logic [7:0] io_window_high;

  masked_cfg_reg #(
    .RESET_VAL  (RST_BRIDGE_COMMAND),
    .WRITE_MASK (WMASK_BRIDGE_COMMAND)
  ) u_command (                           // [R13]
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .wr_en_i (wr_command),
    .wdata_i (cfg_wdata_i),
    .value_o (bridge_command)
  );

  masked_cfg_reg #(
    .RESET_VAL  (RST_LATENCY_SCRATCHPAD),
    .WRITE_MASK (WMASK_SCRATCH_BITS)
  ) u_scratch (                           // [R3]
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .wr_en_i (wr_scratch),
    .wdata_i (cfg_wdata_i),
    .value_o (latency_scratchpad)
  );

  masked_cfg_reg #(
    .RESET_VAL  (RST_DOWNSTREAM_BUS_NUM),
    .WRITE_MASK (WMASK_FULL_BYTE)
  ) u_bus_number (                        // [R6]
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .wr_en_i (wr_bus_number),
    .wdata_i (cfg_wdata_i),
    .value_o (downstream_bus_number)
  );

  masked_cfg_reg #(
    .RESET_VAL  (RST_IO_WINDOW_LOW),
    .WRITE_MASK (WMASK_IO_WINDOW)
  ) u_window_low (                        // [R8] [R12]
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .wr_en_i (wr_window_low),
    .wdata_i (cfg_wdata_i),
    .value_o (io_window_low)
  );

  masked_cfg_reg #(
    .RESET_VAL  (RST_IO_WINDOW_HIGH),
    .WRITE_MASK (WMASK_IO_WINDOW)
  ) u_window_high (                       // [R10] [R12]
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .wr_en_i (wr_window_high),
    .wdata_i (cfg_wdata_i),
    .value_o (io_window_high)
  );

  logic io_access_enable;
  assign io_access_enable = bridge_command[IO_ACCESS_ENABLE_BIT];

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] rdata_next;

  always_comb begin
    case (cfg_addr_i)
      OFF_BRIDGE_COMMAND:      rdata_next = bridge_command;
      OFF_BRIDGE_SUBCLASS:     rdata_next = VAL_SUB_CLASS_CODE;      // [R1]
      OFF_BRIDGE_BASE_CLASS:   rdata_next = VAL_BASE_CLASS_CODE;     // [R2]
      OFF_LATENCY_SCRATCHPAD:  rdata_next = latency_scratchpad;      // [R3]
      OFF_HEADER_LAYOUT_TYPE:  rdata_next = VAL_HEADER_KIND;         // [R4]
      OFF_UPSTREAM_BUS_NUMBER: rdata_next = VAL_UPSTREAM_BUS_NUMBER; // [R5]
      OFF_DOWNSTREAM_BUS_NUM:  rdata_next = downstream_bus_number;   // [R6]
      OFF_DOWNSTREAM_LATENCY:  rdata_next = VAL_DOWNSTREAM_LATENCY;  // [R7]
      OFF_IO_WINDOW_LOW:       rdata_next = io_window_low;           // [R8]
      OFF_IO_WINDOW_HIGH:      rdata_next = io_window_high;          // [R10]
      default:                 rdata_next = RD_UNMAPPED;             // [R14]
    endcase
  end

  // Data is held between reads so a slow reader can sample late
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cfg_rdata_o <= RD_UNMAPPED;
    end else if (cfg_rd_i) begin
      cfg_rdata_o <= rdata_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
    end
  end

  // ---------------------------------------------------------------
  // I/O window decode
  // ---------------------------------------------------------------
  logic window_hit;

  io_window_match u_match (
    .low_field_i  (io_window_low[IO_FIELD_MSB:IO_FIELD_LSB]),
    .high_field_i (io_window_high[IO_FIELD_MSB:IO_FIELD_LSB]),
    .enable_i     (io_access_enable),
    .addr_i       (io_addr_i),
    .hit_o        (window_hit)
  );

  // ---------------------------------------------------------------
  // Downstream forwarding
  // ---------------------------------------------------------------
  // Decode uses the window as it stands in the request cycle; a
  // config write in the same cycle takes effect for the next request.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      link_req_o <= 1'b0;
      io_miss_o  <= 1'b0;
    end else begin
      link_req_o <= io_req_i && window_hit;  // [R11] [R13]
      io_miss_o  <= io_req_i && !window_hit;
    end
  end

  // Payload only moves on a forwarded request, so the link side
  // never sees addresses outside the window
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      link_addr_o  <= '0;
      link_write_o <= 1'b0;
      link_wdata_o <= '0;
      link_be_o    <= '0;
    end else if (io_req_i && window_hit) begin // [R11]
      link_addr_o  <= io_addr_i;
      link_write_o <= io_write_i;
      link_wdata_o <= io_wdata_i;
      link_be_o    <= io_be_i;
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      downstream_bus_o   <= RST_DOWNSTREAM_BUS_NUM;
      io_access_enable_o <= 1'b0;
    end else begin
      downstream_bus_o   <= downstream_bus_number;
      io_access_enable_o <= io_access_enable;
    end
  end

endmodule

`default_nettype wire

// [bridge_cfg_monitor.sv]
/*
  Port-level checker for the bridge configuration bank and I/O window.
  Assumes it is bound to the top module; reset is synchronous, active low.
*/
`timescale 1ns/1ps
`default_nettype none

module bridge_cfg_monitor (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic        cfg_wr_i,
  input wire logic [7:0]  cfg_wdata_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_rdata_o,
  input wire logic        cfg_rvalid_o,
  input wire logic        io_req_i,
  input wire logic [15:0] io_addr_i,
  input wire logic        link_req_o,
  input wire logic [15:0] link_addr_o,
  input wire logic        io_miss_o,
  input wire logic [7:0]  downstream_bus_o,
  input wire logic        io_access_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ---------------------------------------------------------------
  // Config reads
  // ---------------------------------------------------------------
  // Back-to-back reads keep the valid high, so each edge is checked alone
  a_read_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read answer missing");
  a_read_quiet: assert property (!cfg_rd_i |=> !cfg_rvalid_o)
    else $error("read answer without read");
  a_sub_class: assert property (cfg_rd_i && cfg_addr_i == 8'h0a |=> cfg_rdata_o == 8'h04)
    else $error("sub class wrong");
  a_base_class: assert property (cfg_rd_i && cfg_addr_i == 8'h0b |=> cfg_rdata_o == 8'h06)
    else $error("base class wrong");
  a_scratch_low_zero: assert property (cfg_rd_i && cfg_addr_i == 8'h0d |=> cfg_rdata_o[2:0] == 3'h0)
    else $error("scratch low bits set");
  a_header_kind: assert property (cfg_rd_i && cfg_addr_i == 8'h0e |=> cfg_rdata_o == 8'h01)
    else $error("header kind wrong");
  a_upstream_zero: assert property (cfg_rd_i && cfg_addr_i == 8'h18 |=> cfg_rdata_o == 8'h00)
    else $error("upstream bus not zero");
  a_latency_zero: assert property (cfg_rd_i && cfg_addr_i == 8'h1b |=> cfg_rdata_o == 8'h00)
    else $error("downstream latency not zero");
  a_window_res_zero: assert property (cfg_rd_i && cfg_addr_i[7:1] == 7'h0e |=> cfg_rdata_o[3:0] == 4'h0)
    else $error("window reserved bits set");

  // ---------------------------------------------------------------
  // Status copies and window
  // ---------------------------------------------------------------
  a_bus_copy: assert property (cfg_wr_i && cfg_addr_i == 8'h19 |=> ##1 downstream_bus_o == $past(cfg_wdata_i, 2))
    else $error("bus number copy wrong");
  a_one_answer: assert property (io_req_i |=> link_req_o != io_miss_o)
    else $error("io answer not exactly one");
  a_no_stray: assert property (!io_req_i |=> !link_req_o && !io_miss_o)
    else $error("io answer without request");
  a_link_addr: assert property (io_req_i ##1 link_req_o |-> link_addr_o == $past(io_addr_i))
    else $error("link address not copied");
  // Enable output lags one cycle, so skip cycles right after a write
  a_gate_off: assert property (io_req_i && !io_access_enable_o && !$past(cfg_wr_i) |=> !link_req_o)
    else $error("forward while disabled");

  c_forward: cover property (link_req_o);
  c_miss: cover property (io_miss_o);
  c_bus_write: cover property (cfg_wr_i && cfg_addr_i == 8'h19);
endmodule

bind bridge_config_header_io_window bridge_cfg_monitor mon (
  .clk_i(clk_i), .rstn_i(rstn_i), .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i),
  .cfg_wdata_i(cfg_wdata_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_rvalid_o(cfg_rvalid_o), .io_req_i(io_req_i), .io_addr_i(io_addr_i),
  .link_req_o(link_req_o), .link_addr_o(link_addr_o), .io_miss_o(io_miss_o),
  .downstream_bus_o(downstream_bus_o), .io_access_enable_o(io_access_enable_o));

`default_nettype wire

// [tb.sv]
/*
  Self-checking bench for the bridge configuration bank and I/O window.
  Assumes the package and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bridge_cfg_pkg::*;
  logic        clk_i = 1'b0, rstn_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, io_req_i = 1'b0, io_write_i = 1'b0;
  logic [7:0]  cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o, downstream_bus_o, m [256];
  logic [15:0] io_addr_i = 16'h0000, link_addr_o;
  logic [31:0] io_wdata_i = 32'h0, link_wdata_o;
  logic [3:0]  io_be_i = 4'h0, link_be_o;
  logic        cfg_rvalid_o, link_req_o, link_write_o, io_miss_o, io_access_enable_o;
  logic [7:0]  rq [$];
  logic [53:0] iq [$];
  int          fails = 0, total_checks = 0;

  bridge_config_header_io_window uut (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_rvalid_o(cfg_rvalid_o), .io_req_i(io_req_i), .io_addr_i(io_addr_i), .io_write_i(io_write_i),
    .io_wdata_i(io_wdata_i), .io_be_i(io_be_i), .link_req_o(link_req_o), .link_addr_o(link_addr_o),
    .link_write_o(link_write_o), .link_wdata_o(link_wdata_o), .link_be_o(link_be_o), .io_miss_o(io_miss_o),
    .downstream_bus_o(downstream_bus_o), .io_access_enable_o(io_access_enable_o));

  always #4 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // Register model: writable masks and reset values
  // ---------------------------------------------------------------
  function automatic logic [7:0] wm(input logic [7:0] a);
    case (a)
      8'h04: return 8'h01;
      8'h0d: return 8'hf8;
      8'h19: return 8'hff;
      8'h1c, 8'h1d: return 8'hf0;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rv(input logic [7:0] a);
    case (a)
      8'h0a: return 8'h04;
      8'h0b: return 8'h06;
      8'h0e: return 8'h01;
      8'h1c: return 8'hf0;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Drivers: put, get and io own one cycle each, idle one per count; strobes restated every cycle
  // ---------------------------------------------------------------
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {cfg_rd_i, io_req_i, cfg_wr_i} = 3'b001;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    m[a] = (m[a] & ~wm(a)) | (d & wm(a));
  endtask

  task automatic get(input logic [7:0] a);
    @(negedge clk_i);
    {cfg_wr_i, io_req_i, cfg_rd_i} = 3'b001;
    cfg_addr_i = a;
    rq.push_back(m[a]);
  endtask

  task automatic io(input logic [15:0] a);
    logic f;
    @(negedge clk_i);
    {cfg_wr_i, cfg_rd_i, io_req_i} = 3'b001;
    io_addr_i = a;
    io_write_i = 1'($urandom);
    io_wdata_i = $urandom;
    io_be_i = 4'($urandom);
    f = m[8'h04][0] && a >= {m[8'h1c][7:4], 12'h000} && a <= {m[8'h1d][7:4], 12'hfff};
    iq.push_back({f, io_write_i, a, io_wdata_i, io_be_i});
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_i);
      {cfg_wr_i, cfg_rd_i, io_req_i} = 3'b000;
    end
  endtask

  // ---------------------------------------------------------------
  // Scoreboard: oldest note against each answer
  // ---------------------------------------------------------------
  // Outputs settle after the rising edge; look at them half a cycle later
  always @(negedge clk_i) begin
    logic [53:0] e;
    if (rstn_i && cfg_rvalid_o) chk(cfg_rdata_o, rq.size() ? rq.pop_front() : 8'hxx);
    if (rstn_i && (link_req_o || io_miss_o)) begin
      e = iq.size() ? iq.pop_front() : 54'hx;
      chk({link_req_o, link_req_o ? {link_write_o, link_addr_o, link_wdata_o, link_be_o} : e[52:0]}, e);
    end
  end

  initial begin
    #(5000 * 8);
    fails++;
    test_done;
  end

  initial begin
    logic [7:0] offs [11] = '{8'h04, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h18, 8'h19, 8'h1b, 8'h1c, 8'h1d, 8'h20};
    logic [15:0] ra;
    for (int i = 0; i < 256; i++) m[i] = rv(8'(i));
    void'($urandom(75));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    foreach (offs[i]) get(offs[i]);
    for (int k = 0; k < 2; k++) begin
      foreach (offs[i]) put(offs[i], k ? 8'hff : 8'($urandom));
      foreach (offs[i]) get(offs[i]);
    end
    put(8'h19, 8'h5a);
    put(8'h04, 8'h01);
    idle(2);
    chk(downstream_bus_o, 8'h5a);
    chk(io_access_enable_o, 1'b1);
    put(8'h1c, 8'hf0);
    put(8'h1d, 8'h00);
    io(16'h0000);
    io(16'hffff);
    put(8'h1c, 8'h20);
    put(8'h1d, 8'h3f);
    put(8'h04, 8'h00);
    io(16'h3000);
    put(8'h04, 8'h01);
    io(16'h1fff);
    io(16'h2000);
    io(16'h3fff);
    io(16'h4000);
    repeat (40) begin
      put(8'h1c, 8'($urandom));
      put(8'h1d, 8'($urandom));
      ra = 16'($urandom);
      io(ra);
      io({m[8'h1c][7:4], 12'h000});
      io({m[8'h1d][7:4], 12'hfff});
    end
    idle(4);
    chk(rq.size() + iq.size(), 0);
    test_done;
  end
endmodule

`default_nettype wire
